// *** common/boot_rom_defs.svh ***
// register offsets, field positions, reset values and decode constants
`ifndef BOOT_ROM_DEFS_SVH
`define BOOT_ROM_DEFS_SVH
// register byte addresses
`define BLK_A_OFS 32'hfef80050
`define BLK_B_OFS 32'hfef80058
// field positions inside a base/size word
`define F_BASE_HI 31
`define F_BASE_LO 20
`define F_WIDE 19
`define F_SIZ_HI 18
`define F_SIZ_LO 16
`define F_RV 2
`define F_EN 1
`define F_WE 0
// reset values
`define BASE_A_RST 12'hff0
`define BASE_B_RST 12'hff4
`define SIZ_RST 3'h0
// size code with no decode
`define SIZ_RESERVED 3'h7
// upper address bits of the top 1 Mbyte window
`define VEC_WIN 12'hfff
// strap positions
`define STRAP_RV_A 0
`define STRAP_RV_B 1
`define STRAP_WIDE_A 2
`define STRAP_WIDE_B 3
// accepted write sizes in bytes
`define WR_NARROW_BYTES 6'h01
`define WR_WIDE_BYTES 6'h04
// strap settle count after reset release
`define STRAP_SETTLE 2'h2
`endif

// *** common/boot_rom_pkg.sv ***
// types shared by the boot block decoder
package boot_rom_pkg;
   typedef logic [11:0] base_t;   // upper twelve address bits
   typedef logic [2:0]  siz_t;    // block size code
   typedef logic [25:0] ofs_t;    // offset inside a 64 Mbyte block
   typedef logic [5:0]  bytes_t;  // transfer size in bytes
   // ahb data phase kind
   typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} phase_t;
endpackage

// *** common/block_cfg_if.sv ***
// configuration of one boot block, passed to its address matcher
`timescale 1ns/1ps
interface block_cfg_if;
   import boot_rom_pkg::*;
   base_t base;  // programmed base
   siz_t  siz;   // size code
   logic  en;    // range decode enable
   modport src (output base, output siz, output en);
   modport dst (input base, input siz, input en);
endinterface

// *** core/strap_capture.sv ***
// synchronises strap pins and flags the one cycle to latch them
`timescale 1ns/1ps
`include "boot_rom_defs.svh"
module strap_capture #(
   parameter int W = 4
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] strap_pin,
   output logic      [W-1:0] strap_val,
   output logic              strap_load
);
   logic [W-1:0] sync1_q;  // first stage, read only by the second
   logic [W-1:0] sync2_q;  // settled strap levels
   logic [1:0]   cnt_q;    // cycles since release

   ////////////////////////////////////////////////////////////////
   // two-stage synchroniser
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= strap_pin;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // count until the second stage holds a post-release sample
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cnt_q <= 2'h0;
      else if (cnt_q != 2'h3)
         cnt_q <= cnt_q + 2'h1;
   end

   assign strap_val  = sync2_q;
   assign strap_load = (cnt_q == `STRAP_SETTLE);
endmodule

// *** core/block_match.sv ***
// compares an address with one block's base, masked by its size
`timescale 1ns/1ps
`include "boot_rom_defs.svh"
module block_match
   import boot_rom_pkg::*;
(
   input  wire logic [31:0]     addr,
   block_cfg_if.dst             cfg,
   output logic                 hit,
   output boot_rom_pkg::ofs_t   offset
);
   // ones on base bits that take part in the compare
   function automatic base_t size_mask(input siz_t s);
      size_mask = 12'hfff << s;
   endfunction

   base_t mask;  // compare mask for this size

   ////////////////////////////////////////////////////////////////
   // range decode
   always_comb
   begin
      mask = size_mask(cfg.siz);
      // low base bits below the size are ignored  see [R2]
      hit  = cfg.en  // see [R10]
             && (cfg.siz != `SIZ_RESERVED)  // see [R18]
             && (((addr[31:20] ^ cfg.base) & mask) == 12'h000);  // see [R1]
      // offset keeps the address bits that the mask drops
      offset = {addr[25:20] & ~mask[5:0], addr[19:0]};
   end
endmodule

// *** core/boot_rom_decode.sv ***
// boot block A/B decode and write gating with an ahb-lite register port
// Functional notes
// [R1] block A base compares address bits 0-11; the code compares address bits 31-20 with the base
// [R2] larger sizes ignore low base bits
// [R3] reset loads bases FF0 and FF4
// [R4] A in top window if only A
// [R5] vector bits pick top window source
// [R6] A vector bit from strap zero
// [R7] width bit selects 16 or 64 bits
// [R8] A width from strap two, read-only
// [R9] size code doubles from 1MB
// [R10] A range decodes only when enabled
// [R11] disabled valid write ends without write
// [R12] narrow takes bytes, wide aligned words
// [R13] other writes ignored, reads always end
// [R14] software avoids block around base writes
// [R15] software keeps ranges off other slaves
// [R16] B in top window when B set
// [R17] B vector bit from strap one
// [R18] reserved size code never matches
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "boot_rom_defs.svh"
module boot_rom_decode
   import boot_rom_pkg::*;
(
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic      [31:0]          hrdata,
   input  wire logic                 local_bus_reset,
   input  wire logic [3:0]           strap_pin,
   input  wire logic                 acc_valid,
   input  wire logic [31:0]          acc_addr,
   input  wire logic                 acc_write,
   input  wire boot_rom_pkg::bytes_t acc_bytes,
   output logic                      acc_done,
   output logic                      acc_sel_a,
   output logic                      acc_sel_b,
   output logic                      acc_wide,
   output boot_rom_pkg::ofs_t        acc_offset,
   output logic                      rom_write
);
   import boot_rom_pkg::*;

   ////////////////////////////////////////////////////////////////
   // register fields
   base_t  a_base_q;   // block A base
   base_t  b_base_q;   // block B base
   siz_t   a_siz_q;    // block A size code
   siz_t   b_siz_q;    // block B size code
   logic   a_en_q;     // block A range enable
   logic   b_en_q;     // block B range enable
   logic   a_we_q;     // block A write enable
   logic   b_we_q;     // block B write enable
   logic   a_rv_q;     // block_a_vector_source
   logic   b_rv_q;     // block_b_vector_source
   logic   a_wide_q;   // block A 64-bit width
   logic   b_wide_q;   // block B 64-bit width

   // ahb data phase bookkeeping
   phase_t      ph_q;      // kind of pending data phase
   logic [31:0] wr_adr_q;  // address of pending write
   logic [31:0] rdata_q;   // read data for the data phase

   // access port outputs
   logic   done_q;     // normal termination pulse
   logic   sel_a_q;    // block A chosen
   logic   sel_b_q;    // block B chosen
   logic   wide_q;     // width of chosen block
   ofs_t   ofs_q;      // offset inside chosen block
   logic   romwr_q;    // write drive pulse

   // straps
   logic [3:0] strap_val;   // settled strap levels
   logic       strap_load;  // one-cycle latch strobe

   // matcher results
   logic   hit_a;      // address in A range
   logic   hit_b;      // address in B range
   ofs_t   ofs_a;      // offset in A
   ofs_t   ofs_b;      // offset in B

   ////////////////////////////////////////////////////////////////
   // helpers

   // assemble one readable base/size word
   function automatic logic [31:0] reg_word(
      input base_t b,
      input logic  w,
      input siz_t  s,
      input logic  rv,
      input logic  en,
      input logic  we
   );
      logic [31:0] r;
      r = 32'h0000_0000;
      r[`F_BASE_HI:`F_BASE_LO] = b;
      r[`F_WIDE] = w;
      r[`F_SIZ_HI:`F_SIZ_LO] = s;
      r[`F_RV] = rv;
      r[`F_EN] = en;
      r[`F_WE] = we;
      reg_word = r;
   endfunction

   // size and alignment test for a write to a block
   function automatic logic write_ok(
      input logic   wide,
      input bytes_t n,
      input logic [1:0] lo
   );
      if (wide)
         write_ok = (n == `WR_WIDE_BYTES) && (lo == 2'b00);  // see [R12]
      else
         write_ok = (n == `WR_NARROW_BYTES);  // see [R12]
   endfunction

   ////////////////////////////////////////////////////////////////
   // strap synchroniser and matchers
   strap_capture #(
      .W (4)
   ) u_strap (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .strap_pin  (strap_pin),
      .strap_val  (strap_val),
      .strap_load (strap_load)
   );

   block_cfg_if cfg_a ();
   block_cfg_if cfg_b ();

   // drive matcher configuration from the registers
   assign cfg_a.base = a_base_q;
   assign cfg_a.siz  = a_siz_q;
   assign cfg_a.en   = a_en_q;
   assign cfg_b.base = b_base_q;
   assign cfg_b.siz  = b_siz_q;
   assign cfg_b.en   = b_en_q;

   block_match u_match_a (
      .addr   (acc_addr),
      .cfg    (cfg_a),
      .hit    (hit_a),
      .offset (ofs_a)
   );

   block_match u_match_b (
      .addr   (acc_addr),
      .cfg    (cfg_b),
      .hit    (hit_b),
      .offset (ofs_b)
   );

   ////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   logic addr_ph;  // address phase taken this edge
   assign addr_ph = hsel && htrans[1] && hready;

   // data phase kind and write address
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_q     <= PH_IDLE;
         wr_adr_q <= 32'h0000_0000;
      end
      else if (hready)
      begin
         if (!addr_ph)
            ph_q <= PH_IDLE;
         else if (hwrite)
            ph_q <= PH_WRITE;
         else
            ph_q <= PH_READ;
         wr_adr_q <= haddr;
      end
   end

   // read data captured in the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rdata_q <= 32'h0000_0000;
      else if (addr_ph && !hwrite)
      begin
         if (haddr == `BLK_A_OFS)
            rdata_q <= reg_word(a_base_q, a_wide_q, a_siz_q, a_rv_q, a_en_q, a_we_q);
         else if (haddr == `BLK_B_OFS)
            rdata_q <= reg_word(b_base_q, b_wide_q, b_siz_q, b_rv_q, b_en_q, b_we_q);
         else
            rdata_q <= 32'h0000_0000;  // unmapped reads zero
      end
   end

   logic wr_a;  // data phase write to block A register
   logic wr_b;  // data phase write to block B register
   assign wr_a = (ph_q == PH_WRITE) && (wr_adr_q == `BLK_A_OFS);
   assign wr_b = (ph_q == PH_WRITE) && (wr_adr_q == `BLK_B_OFS);

   ////////////////////////////////////////////////////////////////
   // block A base, size, enables; local reset wins over a write
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_base_q <= `BASE_A_RST;  // see [R3]
         a_siz_q  <= `SIZ_RST;
         a_en_q   <= 1'b0;
         a_we_q   <= 1'b0;
      end
      else if (local_bus_reset)
      begin
         a_base_q <= `BASE_A_RST;  // see [R3]
         a_en_q   <= 1'b0;
         a_we_q   <= 1'b0;
      end
      else if (wr_a)
      begin
         a_base_q <= hwdata[`F_BASE_HI:`F_BASE_LO];
         a_siz_q  <= hwdata[`F_SIZ_HI:`F_SIZ_LO];  // see [R9]
         a_en_q   <= hwdata[`F_EN];
         a_we_q   <= hwdata[`F_WE];
      end
   end

   // block B base, size, enables
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         b_base_q <= `BASE_B_RST;  // see [R3]
         b_siz_q  <= `SIZ_RST;
         b_en_q   <= 1'b0;
         b_we_q   <= 1'b0;
      end
      else if (local_bus_reset)
      begin
         b_base_q <= `BASE_B_RST;  // see [R3]
         b_en_q   <= 1'b0;
         b_we_q   <= 1'b0;
      end
      else if (wr_b)
      begin
         b_base_q <= hwdata[`F_BASE_HI:`F_BASE_LO];
         b_siz_q  <= hwdata[`F_SIZ_HI:`F_SIZ_LO];  // see [R9]
         b_en_q   <= hwdata[`F_EN];
         b_we_q   <= hwdata[`F_WE];
      end
   end

   ////////////////////////////////////////////////////////////////
   // vector source bits: strap at power-up, then writable
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_rv_q <= 1'b0;
         b_rv_q <= 1'b0;
      end
      else if (strap_load)
      begin
         a_rv_q <= strap_val[`STRAP_RV_A];  // see [R6]
         b_rv_q <= strap_val[`STRAP_RV_B];  // see [R17]
      end
      else
      begin
         if (wr_a)
            a_rv_q <= hwdata[`F_RV];
         if (wr_b)
            b_rv_q <= hwdata[`F_RV];
      end
   end

   // width bits: strap only, software writes never reach them
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_wide_q <= 1'b0;
         b_wide_q <= 1'b0;
      end
      else if (strap_load)
      begin
         a_wide_q <= strap_val[`STRAP_WIDE_A];  // see [R8]
         b_wide_q <= strap_val[`STRAP_WIDE_B];
      end
   end

   ////////////////////////////////////////////////////////////////
   // block selection for a processor access
   logic   in_win;   // address in top 1 Mbyte window
   logic   pick_a;   // block A answers
   logic   pick_b;   // block B answers
   logic   pick_w;   // width of answering block
   logic   pick_we;  // write enable of answering block
   ofs_t   pick_o;   // offset inside answering block
   logic   answer;   // access terminates normally

   always_comb
   begin
      in_win  = (acc_addr[31:20] == `VEC_WIN);
      pick_a  = 1'b0;
      pick_b  = 1'b0;
      pick_o  = {6'h00, acc_addr[19:0]};  // lowest 1 Mbyte of a block
      // top window source: 01 and 11 give B, 10 gives A  see [R5]
      if (in_win && b_rv_q)
         pick_b = 1'b1;  // see [R16]
      else if (in_win && a_rv_q)
         pick_a = 1'b1;  // see [R4]
      else if (hit_a)
      begin
         pick_a = 1'b1;
         pick_o = ofs_a;
      end
      else if (hit_b)
      begin
         pick_b = 1'b1;
         pick_o = ofs_b;
      end
      // 16-bit or 64-bit device on the chosen block  see [R7]
      pick_w  = pick_a ? a_wide_q : b_wide_q;
      pick_we = pick_a ? a_we_q : b_we_q;
      // reads end on a chosen block; writes only at a legal size  see [R13]
      answer  = acc_valid && (pick_a || pick_b)
                && (!acc_write || write_ok(pick_w, acc_bytes, acc_addr[1:0]));
   end

   ////////////////////////////////////////////////////////////////
   // registered answer to the access port
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         done_q  <= 1'b0;
         sel_a_q <= 1'b0;
         sel_b_q <= 1'b0;
         wide_q  <= 1'b0;
         ofs_q   <= '0;
         romwr_q <= 1'b0;
      end
      else
      begin
         done_q  <= answer;
         sel_a_q <= answer && pick_a;
         sel_b_q <= answer && pick_b;
         wide_q  <= pick_w;
         ofs_q   <= pick_o;
         // a disabled legal write still ends, with no drive  see [R11]
         romwr_q <= answer && acc_write && pick_we;
      end
   end

   assign acc_done   = done_q;
   assign acc_sel_a  = sel_a_q;
   assign acc_sel_b  = sel_b_q;
   assign acc_wide   = wide_q;
   assign acc_offset = ofs_q;
   assign rom_write  = romwr_q;
endmodule

// *** verif/boot_rom_props_properties.sv ***
// concurrent checks on the boot block decoder ports
`timescale 1ns/1ps
module boot_rom_props
   import boot_rom_pkg::*;
(
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic                 acc_valid,
   input wire logic [31:0]          acc_addr,
   input wire logic                 acc_write,
   input wire boot_rom_pkg::bytes_t acc_bytes,
   input wire logic                 acc_done,
   input wire logic                 acc_sel_a,
   input wire logic                 acc_sel_b,
   input wire logic                 acc_wide,
   input wire logic                 rom_write
);
   import boot_rom_pkg::*;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // write requests that must stay unanswered
   sequence s_bad_size;
      acc_valid && acc_write && !(acc_bytes inside {6'h01, 6'h04});
   endsequence
   sequence s_misalign;
      acc_valid && acc_write && acc_bytes == 6'h04 && acc_addr[1:0] != 2'h0;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_bus_always_okay: assert property (hreadyout && !hresp)
      else $error("register bus not ready or not okay");
   a_done_after_req: assert property (acc_done |-> $past(acc_valid))
      else $error("access answered without a request");
   a_bad_size_silent: assert property (s_bad_size |=> !acc_done)
      else $error("write of illegal size answered");
   a_misalign_silent: assert property (s_misalign |=> !acc_done)
      else $error("misaligned word write answered");
   a_wide_word_only: assert property (
      acc_done && $past(acc_write) && acc_wide |-> $past(acc_bytes) == 6'h04)
      else $error("wide block took a non word write");
   a_narrow_byte_only: assert property (
      acc_done && $past(acc_write) && !acc_wide |-> $past(acc_bytes) == 6'h01)
      else $error("narrow block took a non byte write");
   a_write_with_done: assert property (
      rom_write |-> acc_done && $past(acc_write))
      else $error("device write without a written access");
   a_one_block_sel: assert property (acc_done |-> acc_sel_a != acc_sel_b)
      else $error("answer without exactly one block");
   a_quiet_idle: assert property (
      !acc_done |-> !acc_sel_a && !acc_sel_b && !rom_write)
      else $error("block strobe without an answer");
endmodule
bind boot_rom_decode boot_rom_props boot_rom_props_i (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .acc_valid(acc_valid), .acc_addr(acc_addr),
   .acc_write(acc_write), .acc_bytes(acc_bytes), .acc_done(acc_done),
   .acc_sel_a(acc_sel_a), .acc_sel_b(acc_sel_b), .acc_wide(acc_wide),
   .rom_write(rom_write));

// *** verif/rom_model.sv ***
// far side device model: counts writes that reach the rom/flash
`timescale 1ns/1ps
module rom_model
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic rom_write,
   output int        write_count
);
   // one count per device write strobe
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         write_count <= 0;
      else if (rom_write === 1'b1)
         write_count <= write_count + 1;
   end
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the boot block decoder
`timescale 1ns/1ps
`include "boot_rom_defs.svh"
module tb_top;
   import boot_rom_pkg::*;
   logic hclk, hresetn, hsel, hwrite, lbr, acc_valid, acc_write;
   logic [31:0] haddr, hwdata, acc_addr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] strap_pin;
   bytes_t acc_bytes;
   wire logic hready, hreadyout, hresp, acc_done, acc_sel_a, acc_sel_b, acc_wide, rom_write;
   wire logic [31:0] hrdata;
   ofs_t acc_offset;
   int err_count, total_checks, write_count;
   logic [31:0] d;
   assign hready = hreadyout;
   boot_rom_decode boot_rom_decode_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .local_bus_reset(lbr), .strap_pin(strap_pin), .acc_valid(acc_valid),
      .acc_addr(acc_addr), .acc_write(acc_write), .acc_bytes(acc_bytes),
      .acc_done(acc_done), .acc_sel_a(acc_sel_a), .acc_sel_b(acc_sel_b),
      .acc_wide(acc_wide), .acc_offset(acc_offset), .rom_write(rom_write));
   rom_model rom_model_i (.hclk(hclk), .hresetn(hresetn), .rom_write(rom_write),
      .write_count(write_count));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            err_count++;
            print_verdict();
         end
         @(posedge hclk);
      end
   endtask
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] v,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= v;
      wait_rdy();
      r = hrdata;
   endtask
   // register write flanked by register reads; bases keep off other slaves
   task automatic set_blk(input logic [31:0] a, input logic [31:0] v);
      logic [31:0] r;
      ahb(`BLK_A_OFS, 1'b0, 32'h0, r);
      ahb(`BLK_B_OFS, 1'b0, 32'h0, r);
      ahb(a, 1'b1, v, r);
      ahb(`BLK_A_OFS, 1'b0, 32'h0, r);
      ahb(`BLK_B_OFS, 1'b0, 32'h0, r);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(a, 1'b0, 32'h0, r);
      chk(r === e, "register read value");
   endtask
   // one processor access; answer checked one edge after the request
   task automatic acc(input logic [31:0] a, input logic w, input bytes_t n,
                      input logic dn, input logic sa, input ofs_t o, input logic rw);
      @(posedge hclk);
      acc_valid <= 1'b1;
      acc_addr <= a;
      acc_write <= w;
      acc_bytes <= n;
      @(posedge hclk);
      acc_valid <= 1'b0;
      #1;
      chk(acc_done === dn && (!dn || (acc_sel_a === sa && acc_sel_b === !sa
         && acc_offset === o && rom_write === rw
         && acc_wide === (sa ? strap_pin[`STRAP_WIDE_A] : strap_pin[`STRAP_WIDE_B]))),
         "access response");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk(`BLK_A_OFS, 32'hff080004);
      rd_chk(`BLK_B_OFS, 32'hff400004);
      rd_chk(32'hfef80054, 32'h0);
   endtask
   task automatic t_window();
      acc(32'hfff00010, 1'b0, 6'h04, 1'b1, 1'b0, 26'h10, 1'b0);
      set_blk(`BLK_B_OFS, 32'hff400000);
      acc(32'hfff00020, 1'b0, 6'h04, 1'b1, 1'b1, 26'h20, 1'b0);
      set_blk(`BLK_A_OFS, 32'hff000000);
      rd_chk(`BLK_A_OFS, 32'hff080000);
      acc(32'hfff00000, 1'b0, 6'h04, 1'b0, 1'b0, 26'h0, 1'b0);
   endtask
   task automatic t_decode();
      set_blk(`BLK_A_OFS, 32'h12310002);
      acc(32'h12300004, 1'b0, 6'h01, 1'b1, 1'b1, 26'h100004, 1'b0);
      acc(32'h12400000, 1'b0, 6'h01, 1'b0, 1'b1, 26'h0, 1'b0);
      set_blk(`BLK_A_OFS, 32'h12360002);
      acc(32'h10000008, 1'b0, 6'h04, 1'b1, 1'b1, 26'h8, 1'b0);
      acc(32'h13fffffc, 1'b0, 6'h04, 1'b1, 1'b1, 26'h3fffffc, 1'b0);
      acc(32'h14000000, 1'b0, 6'h04, 1'b0, 1'b1, 26'h0, 1'b0);
      set_blk(`BLK_A_OFS, 32'h12370002);
      acc(32'h12300000, 1'b0, 6'h04, 1'b0, 1'b1, 26'h0, 1'b0);
      set_blk(`BLK_A_OFS, 32'h12310000);
      acc(32'h12300004, 1'b0, 6'h04, 1'b0, 1'b1, 26'h0, 1'b0);
   endtask
   task automatic t_writes();
      bytes_t bad[7];
      bad = '{6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h08, 6'h20};
      set_blk(`BLK_A_OFS, 32'h12300002);
      acc(32'h12300000, 1'b1, 6'h04, 1'b1, 1'b1, 26'h0, 1'b0);
      acc(32'h12300000, 1'b1, 6'h01, 1'b0, 1'b1, 26'h0, 1'b0);
      acc(32'h12300002, 1'b1, 6'h04, 1'b0, 1'b1, 26'h0, 1'b0);
      foreach (bad[i])
         acc(32'h12300000, 1'b1, bad[i], 1'b0, 1'b1, 26'h0, 1'b0);
      set_blk(`BLK_A_OFS, 32'h12300003);
      acc(32'h12300004, 1'b1, 6'h04, 1'b1, 1'b1, 26'h4, 1'b1);
      set_blk(`BLK_B_OFS, 32'h20000003);
      acc(32'h20000001, 1'b1, 6'h01, 1'b1, 1'b0, 26'h1, 1'b1);
      acc(32'h20000000, 1'b1, 6'h04, 1'b0, 1'b0, 26'h0, 1'b0);
      chk(write_count == 2, "device write count");
   endtask
   task automatic t_local_reset();
      @(posedge hclk);
      lbr <= 1'b1;
      @(posedge hclk);
      lbr <= 1'b0;
      rd_chk(`BLK_A_OFS, 32'hff080000);
      rd_chk(`BLK_B_OFS, 32'hff400000);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial
   begin
      {hresetn, hsel, hwrite, lbr, acc_valid, acc_write} = 6'h00;
      {haddr, hwdata, acc_addr} = '0;
      htrans = 2'h0;
      hsize = 3'h2;
      acc_bytes = 6'h00;
      strap_pin = 4'h7;
      err_count = 0;
      total_checks = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      t_reset();
      t_window();
      t_decode();
      t_writes();
      t_local_reset();
      print_verdict();
   end
endmodule
